// [design/imu_diag_pkg.sv]
// Constants, types and register map of the diagnostic flag register bank.
// Assumes a single 125 MHz clock domain and a 16-bit serial register link.
package imu_diag_pkg;

	localparam int WORD_W = 16;
	localparam int AXIS_W = 32;
	localparam int BIT_CNT_W = 4;
	localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 4'h0;
	localparam logic [BIT_CNT_W-1:0] BIT_LAST = 4'hf;

	localparam int RW_BIT = 15;
	localparam int ADDR_HI = 14;
	localparam int ADDR_LO = 8;
	localparam int ADDR_W = 7;

	localparam logic [ADDR_W-1:0] ADDR_DIAG = 7'h02;
	localparam logic [ADDR_W-1:0] ADDR_X_LOW = 7'h04;
	localparam logic [ADDR_W-1:0] ADDR_X_HIGH = 7'h06;
	localparam logic [ADDR_W-1:0] ADDR_Y_LOW = 7'h08;
	localparam logic [ADDR_W-1:0] ADDR_Y_HIGH = 7'h0a;
	localparam logic [ADDR_W-1:0] ADDR_Z_LOW = 7'h0c;
	localparam logic [ADDR_W-1:0] ADDR_Z_HIGH = 7'h0e;

	localparam int BIT_ACCEL = 10;
	localparam int BIT_GYRO2 = 9;
	localparam int BIT_GYRO1 = 8;
	localparam int BIT_CLOCK = 7;
	localparam int BIT_FLASH_TEST = 6;
	localparam int BIT_SENSOR = 5;
	localparam int BIT_STANDBY = 4;
	localparam int BIT_FRAMING = 3;
	localparam int BIT_UPDATE = 2;
	localparam int BIT_OVERRUN = 1;

	localparam logic [WORD_W-1:0] DIAG_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] DIAG_USED_MASK = 16'h07fe;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [1:0] SYNC_SCALED = 2'b10;

	localparam logic [WORD_W-1:0] RATE16_POS_FS = 16'h4e20;
	localparam logic [WORD_W-1:0] RATE16_NEG_FS = 16'hb1e0;
	localparam logic [WORD_W-1:0] RATE16_NEG_LSB = 16'hffff;
	localparam logic [AXIS_W-1:0] RATE_POS_FS = 32'h4e200000;
	localparam logic [AXIS_W-1:0] RATE_NEG_FS = 32'hb1e00000;

	localparam int CLK_MHZ = 125;
	localparam int STANDBY_TIME_MS = 250;
	localparam int STANDBY_CYCLES = STANDBY_TIME_MS * CLK_MHZ * 1000;
	localparam int HOLD_CNT_W = 32;
	localparam logic [HOLD_CNT_W-1:0] HOLD_ZERO = 32'h00000000;
	localparam logic [HOLD_CNT_W-1:0] HOLD_ONE = 32'h00000001;

	typedef logic [WORD_W-1:0] word_t;

	typedef struct packed {
		logic selftest_done;
		logic accel_fail;
		logic gyro2_fail;
		logic gyro1_fail;
		logic flash_test_done;
		logic crc_mismatch;
		logic update_done;
		logic update_fail;
		logic clock_unlock;
		logic overrun;
	} diag_events_s;

	typedef struct packed {
		logic [AXIS_W-1:0] x;
		logic [AXIS_W-1:0] y;
		logic [AXIS_W-1:0] z;
	} gyro_rates_s;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_LOW = 3'b010,
		ST_WAIT = 3'b100
	} supply_state_e;

endpackage

// [design/sync_two_ff.sv]
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; the first stage feeds only the second.
`timescale 1ns/10ps
module sync_two_ff #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // sync_two_ff

// [design/sticky_flags.sv]
// Bank of sticky flags: set by events, cleared together by one pulse.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/10ps
module sticky_flags #(
	parameter int W = 16,
	parameter logic [W-1:0] MASK = '1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] set,
	input wire logic clr,
	output logic [W-1:0] q
);
	logic [W-1:0] next_q;

	// A set arriving with the clear wins.
	assign next_q = (set | (q & ~{W{clr}})) & MASK;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	chk_set_beats_clear: assert property (@(posedge ref_clk)
		disable iff (!rst_n) clr |=> ((q & $past(set & MASK))
		== $past(set & MASK)))
		else $error("Flag set lost during clear.");
endmodule // sticky_flags

// [design/imu_diag_regs.sv]
// Diagnostic flag register and gyro rate words behind a 16-bit serial link.
// Assumes event inputs come from logic on ref_clk and link pins are async.
//
// Functional notes
// - Read-only flag register at 0x02, reset zero.
// - Reading the flag register clears all flags.
// - Flags hold until read, even after cause ends.
// - Persisting condition sets flag again after read.
// - Bit 10 flags accelerometer self-test failure.
// - Bits 9, 8 flag gyro two, one failures.
// - Bit 5 is OR of bits 10..8.
// - Bit 7 flags sync unlock in scaled mode.
// - Bit 6 flags flash CRC mismatch.
// - Bit 4 standby; resume after 250 ms good supply.
// - Bit 3 flags clock count not multiple of 16.
// - Bit 2 flags failed flash update.
// - Bit 1 flags data path overrun; host resets.
// - Each axis: two words forming 32-bit value.
// - High word spans 2000 dps, 0.1 per LSB.
// - 16-bit codes 0000, 4e20, b1e0, ffff.
// - Low word holds lower bits, x at 0x04.
// - 32-bit full scale 4e200000 and b1e00000.
`timescale 1ns/10ps
module imu_diag_regs #(
	parameter int STANDBY_HOLD = imu_diag_pkg::STANDBY_CYCLES
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	input wire imu_diag_pkg::diag_events_s events,
	input wire logic [1:0] sync_mode,
	input wire logic supply_low,
	input wire imu_diag_pkg::gyro_rates_s rates,
	output logic data_halt,
	output logic reinit_pulse,
	output imu_diag_pkg::word_t error_flags
);
	import imu_diag_pkg::*;

	logic [0:0] rst_sync;
	logic rst_n;
	logic [3:0] pins_s;
	logic cs_n_s;
	logic sclk_s;
	logic mosi_s;
	logic low_s;
	logic sclk_d;
	logic cs_n_d;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic in_frame;
	logic [BIT_CNT_W-1:0] bit_cnt;
	logic [BIT_CNT_W-1:0] next_bit_cnt;
	word_t rx_sreg;
	word_t rx_word;
	word_t tx_sreg;
	word_t next_tx;
	word_t rd_data;
	word_t flags;
	word_t set_vec;
	logic word_done;
	logic is_read;
	logic [ADDR_W-1:0] rd_addr;
	logic sel_diag;
	logic clr_pulse;
	logic frame_err;
	logic any_fail;
	gyro_rates_s rates_c;
	supply_state_e state;
	supply_state_e next_state;
	logic [HOLD_CNT_W-1:0] hold_cnt;
	logic [HOLD_CNT_W-1:0] next_hold_cnt;
	logic hold_done;

	function automatic logic [AXIS_W-1:0] clamp_rate(
		input logic [AXIS_W-1:0] v
	);
		logic [AXIS_W-1:0] r;
		r = v;
		if ($signed(v) > $signed(RATE_POS_FS)) begin
			r = RATE_POS_FS;
		end else if ($signed(v) < $signed(RATE_NEG_FS)) begin
			r = RATE_NEG_FS;
		end
		return r;
	endfunction

	// Reset release and pin synchronisation.
	sync_two_ff #(.W(1)) u_rst_sync (
		.ref_clk(ref_clk),
		.rst_n(nrst),
		.d(1'b1),
		.q(rst_sync)
	);
	assign rst_n = rst_sync[0];

	sync_two_ff #(.W(4)) u_pin_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.d({~spi_cs_n, spi_sclk, spi_mosi, supply_low}),
		.q(pins_s)
	);
	assign cs_n_s = ~pins_s[3];
	assign sclk_s = pins_s[2];
	assign mosi_s = pins_s[1];
	assign low_s = pins_s[0];

	// Link edge detection on the synchronised copies.
	assign in_frame = ~cs_n_s;
	assign sclk_rise = sclk_s & ~sclk_d & in_frame;
	assign sclk_fall = ~sclk_s & sclk_d & in_frame;
	assign cs_rise = cs_n_s & ~cs_n_d;
	assign word_done = sclk_rise & (bit_cnt == BIT_LAST);
	assign rx_word = {rx_sreg[WORD_W-2:0], mosi_s};
	assign is_read = ~rx_word[RW_BIT];
	assign rd_addr = {rx_word[ADDR_HI:ADDR_LO+1], 1'b0};
	assign next_bit_cnt = in_frame ? (sclk_rise ? bit_cnt + 4'h1 : bit_cnt)
		: BIT_FIRST;
	assign frame_err = cs_rise & (bit_cnt != BIT_FIRST);

	// Rate words, clamped to the documented full scale.
	assign rates_c.x = clamp_rate(rates.x);
	assign rates_c.y = clamp_rate(rates.y);
	assign rates_c.z = clamp_rate(rates.z);

	// Read decode; each axis splits into low then high word.
	assign sel_diag = (rd_addr == ADDR_DIAG);
	assign rd_data =
		sel_diag ? flags :
		(rd_addr == ADDR_X_LOW) ? rates_c.x[WORD_W-1:0] :
		(rd_addr == ADDR_X_HIGH) ? rates_c.x[AXIS_W-1:WORD_W] :
		(rd_addr == ADDR_Y_LOW) ? rates_c.y[WORD_W-1:0] :
		(rd_addr == ADDR_Y_HIGH) ? rates_c.y[AXIS_W-1:WORD_W] :
		(rd_addr == ADDR_Z_LOW) ? rates_c.z[WORD_W-1:0] :
		(rd_addr == ADDR_Z_HIGH) ? rates_c.z[AXIS_W-1:WORD_W] :
		WORD_ZERO;
	assign clr_pulse = word_done & is_read & sel_diag;
	assign next_tx = word_done ? (is_read ? rd_data : WORD_ZERO) :
		sclk_fall ? {tx_sreg[WORD_W-2:0], 1'b0} : tx_sreg;

	// Flag sources; level causes keep re-setting after a clear.
	assign any_fail = events.accel_fail | events.gyro2_fail
		| events.gyro1_fail;
	always_comb begin
		set_vec = WORD_ZERO;
		set_vec[BIT_ACCEL] = events.selftest_done & events.accel_fail;
		set_vec[BIT_GYRO2] = events.selftest_done & events.gyro2_fail;
		set_vec[BIT_GYRO1] = events.selftest_done & events.gyro1_fail;
		set_vec[BIT_SENSOR] = events.selftest_done & any_fail;
		set_vec[BIT_CLOCK] = events.clock_unlock
			& (sync_mode == SYNC_SCALED);
		set_vec[BIT_FLASH_TEST] = events.flash_test_done
			& events.crc_mismatch;
		set_vec[BIT_STANDBY] = low_s;
		set_vec[BIT_FRAMING] = frame_err;
		set_vec[BIT_UPDATE] = events.update_done & events.update_fail;
		set_vec[BIT_OVERRUN] = events.overrun;
	end

	sticky_flags #(.W(WORD_W), .MASK(DIAG_USED_MASK)) u_flags (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.set(set_vec),
		.clr(clr_pulse),
		.q(flags)
	);

	// Supply watch: halt while low, resume after a steady good interval.
	assign hold_done = (hold_cnt == HOLD_CNT_W'(STANDBY_HOLD - 1));
	always_comb begin
		next_state = state;
		next_hold_cnt = hold_cnt;
		case (state)
			ST_RUN: begin
				if (low_s) begin
					next_state = ST_LOW;
				end
			end
			ST_LOW: begin
				next_hold_cnt = HOLD_ZERO;
				if (!low_s) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				next_hold_cnt = hold_cnt + HOLD_ONE;
				if (low_s) begin
					next_state = ST_LOW;
				end else if (hold_done) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_LOW;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_RUN;
			hold_cnt <= HOLD_ZERO;
			data_halt <= 1'b0;
			reinit_pulse <= 1'b0;
		end else begin
			state <= next_state;
			hold_cnt <= next_hold_cnt;
			data_halt <= (next_state != ST_RUN);
			reinit_pulse <= (state == ST_WAIT) & (next_state == ST_RUN);
		end
	end

	// Link shift registers; sample on rising, drive on falling edge.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d <= 1'b1;
			cs_n_d <= 1'b1;
			bit_cnt <= BIT_FIRST;
			rx_sreg <= WORD_ZERO;
		end else begin
			sclk_d <= sclk_s;
			cs_n_d <= cs_n_s;
			bit_cnt <= next_bit_cnt;
			if (sclk_rise) begin
				rx_sreg <= rx_word;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_sreg <= WORD_ZERO;
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
			error_flags <= DIAG_RESET;
		end else begin
			tx_sreg <= next_tx;
			if (sclk_fall) begin
				spi_miso <= tx_sreg[WORD_W-1];
			end
			spi_miso_oe <= in_frame;
			error_flags <= flags;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	chk_reset_zero: assert property ($rose(rst_n) |->
		(flags == DIAG_RESET))
		else $error("Flags not zero after reset.");

	chk_read_clears: assert property ((clr_pulse &&
		(set_vec == WORD_ZERO)) |=> (flags == WORD_ZERO))
		else $error("Flag read did not clear.");

	chk_read_returns: assert property ((word_done && is_read
		&& sel_diag) |=> (tx_sreg == $past(flags)))
		else $error("Flag read returned wrong word.");

	chk_flags_hold: assert property (!clr_pulse |=>
		((flags & $past(flags)) == $past(flags)))
		else $error("Flag dropped without a read.");

	chk_persist_reset: assert property ((clr_pulse && low_s)
		|=> flags[BIT_STANDBY])
		else $error("Persisting standby not flagged again.");

	chk_accel_fail: assert property ((events.selftest_done
		&& events.accel_fail) |=> (flags[BIT_ACCEL] && flags[BIT_SENSOR]))
		else $error("Accelerometer failure not flagged.");

	chk_gyro_fail: assert property ((events.selftest_done
		&& events.gyro2_fail) |=> flags[BIT_GYRO2])
		else $error("Gyro two failure not flagged.");

	chk_sensor_or: assert property (flags[BIT_SENSOR] ==
		(|flags[BIT_ACCEL:BIT_GYRO1]))
		else $error("Sensor bit differs from OR of failures.");

	chk_clock_mode: assert property ($rose(flags[BIT_CLOCK]) |->
		$past(events.clock_unlock && (sync_mode == SYNC_SCALED)))
		else $error("Clock flag set outside scaled mode.");

	chk_flash_crc: assert property ((events.flash_test_done
		&& events.crc_mismatch) |=> flags[BIT_FLASH_TEST])
		else $error("Flash test failure not flagged.");

	chk_halt_low: assert property (low_s |=>
		(data_halt && flags[BIT_STANDBY]))
		else $error("Low supply did not halt.");

	chk_resume_wait: assert property ((state == ST_WAIT &&
		!low_s && hold_done) |=> (!data_halt && reinit_pulse))
		else $error("No resume after good supply interval.");

	chk_framing: assert property (frame_err |=>
		flags[BIT_FRAMING])
		else $error("Framing error not flagged.");

	chk_update_fail: assert property ((events.update_done
		&& events.update_fail) |=> flags[BIT_UPDATE])
		else $error("Update failure not flagged.");

	chk_overrun: assert property (events.overrun |=>
		flags[BIT_OVERRUN])
		else $error("Overrun not flagged.");

	chk_rate_range: assert property (($signed(rates_c.x) <=
		$signed(RATE_POS_FS)) && ($signed(rates_c.x) >=
		$signed(RATE_NEG_FS)))
		else $error("Rate outside full scale.");

	chk_reserved_zero: assert property ((flags &
		~DIAG_USED_MASK) == WORD_ZERO)
		else $error("Reserved flag bit set.");

	chk_event_on_clear: assert property ((clr_pulse &&
		events.overrun) |=> flags[BIT_OVERRUN])
		else $error("Event lost during clear.");

	cov_clear_read: cover property (clr_pulse && (flags != WORD_ZERO));
	cov_framing: cover property (frame_err);
	cov_reinit: cover property (reinit_pulse);
	cov_rate_read: cover property (word_done && is_read
		&& (rd_addr == ADDR_X_HIGH));
endmodule // imu_diag_regs

// [testbench/host_link_model.sv]
// Host controller model: drives framed mode 3 words on the register link.
// Assumes the device samples on rising sclk and shifts on falling sclk.
`timescale 1ns/10ps
module host_link_model (
	input wire logic ref_clk,
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe
);
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b1;
		spi_mosi = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Shifts n bits of tx out MSB first, h clock cycles per half period.
	task automatic frame(input logic [31:0] tx, input int n, input int h,
		output logic [31:0] rx);
		rx = 32'h00000000;
		spi_cs_n = 1'b0;
		wt(h);
		for (int i = 0; i < n; i++) begin
			spi_sclk = 1'b0;
			spi_mosi = tx[31-i];
			wt(h);
			rx = {rx[30:0], spi_miso_oe ? spi_miso : 1'bx};
			spi_sclk = 1'b1;
			wt(h);
		end
		spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
		wt(h);
	endtask
endmodule // host_link_model

// [testbench/testbench.sv]
// Self-checking bench for the diagnostic flags and gyro rate words.
// Assumes the host model drives the link; the design holds the assertions.
`timescale 1ns/10ps
module testbench;
	import imu_diag_pkg::*;
	localparam int HOLD = 20;
	logic ref_clk;
	logic nrst;
	logic spi_cs_n;
	logic spi_sclk;
	logic spi_mosi;
	logic spi_miso;
	logic spi_miso_oe;
	diag_events_s ev;
	logic [1:0] sync_mode;
	logic supply_low;
	gyro_rates_s rt;
	logic data_halt;
	logic reinit_pulse;
	word_t error_flags;
	int errors;
	int checks;
	int hp;

	imu_diag_regs #(.STANDBY_HOLD(HOLD)) dut (
		.ref_clk(ref_clk), .nrst(nrst), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe), .events(ev), .sync_mode(sync_mode),
		.supply_low(supply_low), .rates(rt), .data_halt(data_halt),
		.reinit_pulse(reinit_pulse), .error_flags(error_flags)
	);
	host_link_model host (
		.ref_clk(ref_clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe)
	);

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [6:0] a, output word_t d);
		logic [31:0] r;
		host.frame({1'b0, a, 8'h00, 16'h0400}, 32, hp, r);
		d = r[15:0];
	endtask
	task automatic rd32(input logic [6:0] a, output logic [31:0] v);
		word_t lo;
		word_t hi;
		rd(a, lo);
		rd(a + 7'h02, hi);
		v = {hi, lo};
	endtask
	task automatic pulse(input logic [9:0] e);
		ev = diag_events_s'(e);
		step(1);
		ev = diag_events_s'(10'h000);
	endtask
	// Raises one event pattern, then reads the flags twice.
	task automatic ev_case(input logic [9:0] e, input word_t exp);
		word_t d;
		pulse(e);
		step(3);
		rd(ADDR_DIAG, d);
		check(d, exp);
		rd(ADDR_DIAG, d);
		check(d, WORD_ZERO);
	endtask
	task automatic t_reset();
		word_t d;
		check(error_flags, DIAG_RESET);
		check({data_halt, reinit_pulse}, 2'b00);
		rd(ADDR_DIAG, d);
		check(d, DIAG_RESET);
		pulse(10'h001);
		step(3);
		check(error_flags, 16'h0002);
		nrst = 1'b0;
		step(2);
		nrst = 1'b1;
		step(8);
		rd(ADDR_DIAG, d);
		check(d, DIAG_RESET);
	endtask
	task automatic t_selftest();
		logic [9:0] e;
		word_t x;
		for (int i = 0; i < 3; i++) begin
			e = 10'h200 | (10'h100 >> i);
			x = 16'h0020 | (16'h0400 >> i);
			ev_case(e, x);
		end
		ev_case(10'h200, 16'h0000);
		ev_case(10'h1c0, 16'h0000);
		ev_case(10'h3c0, 16'h0720);
	endtask
	task automatic t_events();
		ev_case(10'h030, 16'h0040);
		ev_case(10'h020, 16'h0000);
		ev_case(10'h00c, 16'h0004);
		ev_case(10'h008, 16'h0000);
		ev_case(10'h001, 16'h0002);
	endtask
	task automatic t_sync();
		for (int m = 0; m < 4; m++) begin
			sync_mode = m[1:0];
			step(1);
			ev_case(10'h002, (m == 2) ? 16'h0080 : 16'h0000);
		end
		sync_mode = SYNC_SCALED;
	endtask
	task automatic t_persist();
		word_t d;
		ev.overrun = 1'b1;
		step(3);
		rd(ADDR_DIAG, d);
		check(d, 16'h0002);
		rd(ADDR_DIAG, d);
		check(d, 16'h0002);
		ev.overrun = 1'b0;
		rd(ADDR_DIAG, d);
		check(d, 16'h0002);
		rd(ADDR_DIAG, d);
		check(d, 16'h0000);
	endtask
	task automatic t_refused();
		word_t d;
		logic [31:0] r;
		pulse(10'h001);
		host.frame(32'h82ff0400, 32, hp, r);
		check(r[15:0], WORD_ZERO);
		rd(7'h40, d);
		check(d, WORD_ZERO);
		rd(ADDR_DIAG, d);
		check(d, 16'h0002);
	endtask
	task automatic t_framing();
		word_t d;
		logic [31:0] r;
		host.frame(32'h04000000, 15, hp, r);
		step(3);
		check(error_flags, 16'h0008);
		rd(ADDR_DIAG, d);
		check(d, 16'h0008);
		rd(ADDR_DIAG, d);
		check(d, 16'h0000);
	endtask
	task automatic t_standby();
		word_t d;
		int n;
		supply_low = 1'b1;
		step(6);
		check(data_halt, 1'b1);
		check(error_flags, 16'h0010);
		rd(ADDR_DIAG, d);
		check(d, 16'h0010);
		rd(ADDR_DIAG, d);
		check(d, 16'h0010);
		supply_low = 1'b0;
		step(10);
		supply_low = 1'b1;
		step(4);
		supply_low = 1'b0;
		n = 0;
		while (reinit_pulse !== 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		check(n >= HOLD && n <= HOLD + 6, 1'b1);
		check(data_halt, 1'b0);
		rd(ADDR_DIAG, d);
		check(d, 16'h0010);
	endtask
	task automatic t_rates();
		logic [31:0] v;
		hp = 12;
		rt = {32'h12345678, RATE_NEG_FS, 32'hffff0000};
		step(2);
		rd32(ADDR_X_LOW, v);
		check(v, 32'h12345678);
		rd32(ADDR_Y_LOW, v);
		check(v, 32'hb1e00000);
		rd32(ADDR_Z_LOW, v);
		check(v, 32'hffff0000);
		rt = {32'h7fffffff, 32'h80000000, 32'h00000000};
		step(2);
		rd32(ADDR_X_LOW, v);
		check(v, 32'h4e200000);
		rd32(ADDR_Y_LOW, v);
		check(v, 32'hb1e00000);
		rd32(ADDR_Z_LOW, v);
		check(v, 32'h00000000);
		hp = 8;
	endtask
	task automatic finish_test();
		if (errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial begin
		errors = 0;
		checks = 0;
		hp = 8;
		nrst = 1'b0;
		ev = diag_events_s'(10'h000);
		sync_mode = SYNC_SCALED;
		supply_low = 1'b0;
		rt = '0;
		repeat (2) @(posedge ref_clk);
		#1;
		nrst = 1'b1;
		step(8);
		t_reset();
		t_selftest();
		t_events();
		t_sync();
		t_persist();
		t_refused();
		t_framing();
		t_standby();
		t_rates();
		finish_test();
	end
	initial begin
		repeat (90000) @(posedge ref_clk);
		errors++;
		finish_test();
	end
endmodule // testbench
